/* rtl/ewiu_pkg.sv */
/*
  constants for the external wake interrupt unit: register offsets, reset values, fields.
  assumes a plain register port with byte offsets on a 32-bit word grid.
*/
package ewiu_pkg;
  localparam int          EWIU_NLINES      = 16;
  localparam int          EWIU_AW          = 8;
  localparam logic [7:0]  OFS_SWIRQ_LOW    = 8'h1C;
  localparam logic [7:0]  OFS_SWIRQ_HIGH   = 8'h20;
  localparam logic [7:0]  OFS_LINE_CTRL    = 8'h24;
  localparam logic [7:0]  OFS_MASK_HIGH    = 8'h28;
  localparam logic [7:0]  OFS_MASK_LOW     = 8'h2C;
  localparam logic [7:0]  OFS_EDGE_HIGH    = 8'h30;
  localparam logic [7:0]  OFS_EDGE_LOW     = 8'h34;
  localparam logic [7:0]  OFS_PEND_HIGH    = 8'h38;
  localparam logic [7:0]  OFS_PEND_LOW     = 8'h3C;
  localparam logic [7:0]  OFS_STOP_EXIT    = 8'h40;
  localparam int          CTRL_WAKE_BIT    = 0;
  localparam int          CTRL_GEN_BIT     = 1;
  localparam int          CTRL_STOP_BIT    = 2;
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam int          LINE_SW          = 0;
  localparam int          LINE_USB         = 1;
  localparam int          LINE_WAKEPIN     = 15;
  localparam int          FIRST_PIN_LINE   = 2;
  localparam int          PIN_LINES        = 14;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ONE, SEQ_ZERO, SEQ_STOPPED} ewiu_seq_t;
endpackage : ewiu_pkg

/* rtl/external_wake_interrupt_unit.sv */
/*
  external wake interrupt unit: 16 edge-triggered lines, masks, pending bits,
  interrupt request for channel 5 and the 1-0-1 stop entry tracker.
  assumes pin inputs are asynchronous; the clock power unit reports
  clock restart after oscillator delay and the irq controller reports acknowledges.
*/
// Our own choices: the register addresses and the plain strobed port.
// How it works
// R01: sixteen lines, fourteen pins, two internal
// R02: one combined request to channel five
// R03: line0 software, line1 usb, line15 wakepin/alarm
// R04: per-line mask blocks irq and wake
// R05: per-line rising or falling edge select
// R06: wake-mode bit picks interrupt or wake use
// R07: requests forwarded only with global enable
// R08: stop by writes 1,0,1, gaps allowed
// R09: two zero writes reset the tracker
// R10: acknowledge during sequence aborts stop entry
// R11: enabled line event during sequence refuses stop
// R12: after wake stop reads 0, exit flag 1
// R13: unmasked line event ends stop mode
// R14: pending set on edges, clearable while held
// R15: no stop while unmasked pending bit set
// R16: stop needs at least one unmasked line
// R17: software checks status after stop sequence
// R18: software masks channels for resume-only wake
// R19: wake-mode bit stays readable
// R20: software write raises a line event
// R21: only wakepin leaves standby
// R22: stop succeeds only with wake-mode set
// R23: stop bit 1 after first write and stop
// R24: global enable 0 disables line interrupts
// R25: request is or of unmasked pending, gated
// R26: edge detected after two-flop synchroniser
module ewiu_external_wake_interrupt_unit
  import ewiu_pkg::*;
#(
  parameter int NLINES = EWIU_NLINES
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic [EWIU_AW-1:0]  regAddr,
  input  wire logic [31:0]         regWdata,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic      [31:0]         regRdata,
  input  wire logic [PIN_LINES-1:0] pinLines,
  input  wire logic                usbSuspendExit,
  input  wire logic                rtcAlarm,
  input  wire logic                irqAck,
  input  wire logic                clockResumed,
  output logic                     lineIrq,
  output logic                     stopReq,
  output logic                     standbyWake
);
  if (NLINES != EWIU_NLINES) begin : g_bad_lines
    $error("line count must be 16");
  end

  logic [15:0] maskFf, edgeFf, pendFf, swFf;
  logic [15:0] syncAFf, syncBFf, lineDlyFf;
  logic        wakeModeFf, genEnFf, stopBitFf, stopExitFf;
  logic        wakeSyncAFf, wakeSyncBFf;
  ewiu_seq_t   seqFf, nxt_seq;
  logic [15:0] rawLines, edgeHit, pendClr, pendSet;
  logic        wrCtrl, ctrlStop, stopOk;

  default clocking ewiuCk @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // asynchronous sources collected into line order; line 0 has no pin
  // line 15 wakes on the wake pin or the alarm
  assign rawLines = {rtcAlarm | pinLines[PIN_LINES-1], pinLines[PIN_LINES-2:0],
                     usbSuspendExit, 1'b0}; // [R01] [R03]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncAFf     <= 16'h0000;
      syncBFf     <= 16'h0000;
      lineDlyFf   <= 16'h0000;
      wakeSyncAFf <= 1'b0;
      wakeSyncBFf <= 1'b0;
    end else begin
      syncAFf     <= rawLines; // [R26]
      syncBFf     <= syncAFf;
      lineDlyFf   <= syncBFf;
      wakeSyncAFf <= pinLines[PIN_LINES-1];
      wakeSyncBFf <= wakeSyncAFf;
    end
  end

  // rising when edge bit is 1, falling when 0
  assign edgeHit = (edgeFf & syncBFf & ~lineDlyFf) | (~edgeFf & ~syncBFf & lineDlyFf); // [R05] [R14]
  assign pendSet = (edgeHit | swFf) & maskFf; // [R04] [R20]
  assign pendClr = (regWr && regAddr == OFS_PEND_LOW)  ? {8'h00, regWdata[7:0]} :
                   (regWr && regAddr == OFS_PEND_HIGH) ? {regWdata[7:0], 8'h00} : 16'h0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pendFf <= 16'h0000;
    end else begin
      pendFf <= (pendFf & ~pendClr) | pendSet; // [R14]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      maskFf <= 16'h0000;
      edgeFf <= 16'h0000;
      swFf   <= 16'h0000;
    end else if (regWr) begin
      if (regAddr == OFS_MASK_LOW)   maskFf[7:0]  <= regWdata[7:0]; // [R04]
      if (regAddr == OFS_MASK_HIGH)  maskFf[15:8] <= regWdata[7:0];
      if (regAddr == OFS_EDGE_LOW)   edgeFf[7:0]  <= regWdata[7:0]; // [R05]
      if (regAddr == OFS_EDGE_HIGH)  edgeFf[15:8] <= regWdata[7:0];
      if (regAddr == OFS_SWIRQ_LOW)  swFf[7:0]    <= regWdata[7:0]; // [R20]
      if (regAddr == OFS_SWIRQ_HIGH) swFf[15:8]   <= regWdata[7:0];
    end
  end

  assign wrCtrl   = regWr && regAddr == OFS_LINE_CTRL;
  assign ctrlStop = regWdata[CTRL_STOP_BIT];
  // entry conditions checked on the third write
  assign stopOk   = wakeModeFf && (maskFf != 16'h0000) &&
                    ((pendFf & maskFf) == 16'h0000) && (pendSet == 16'h0000); // [R15] [R16] [R22]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wakeModeFf <= 1'b0;
      genEnFf    <= 1'b0;
    end else if (wrCtrl) begin
      wakeModeFf <= regWdata[CTRL_WAKE_BIT]; // [R06] [R19]
      genEnFf    <= regWdata[CTRL_GEN_BIT]; // [R24]
    end
  end

  always_comb begin
    nxt_seq = seqFf;
    unique case (seqFf)
      SEQ_IDLE: begin
        if (wrCtrl && ctrlStop) nxt_seq = SEQ_ONE; // [R08]
      end
      SEQ_ONE: begin
        if (irqAck || pendSet != 16'h0000) nxt_seq = SEQ_IDLE; // [R10] [R11]
        else if (wrCtrl && !ctrlStop) nxt_seq = SEQ_ZERO;
      end
      SEQ_ZERO: begin
        if (irqAck || pendSet != 16'h0000) nxt_seq = SEQ_IDLE; // [R10] [R11]
        else if (wrCtrl && !ctrlStop) nxt_seq = SEQ_IDLE; // [R09]
        else if (wrCtrl && ctrlStop) nxt_seq = stopOk ? SEQ_STOPPED : SEQ_IDLE; // [R08]
      end
      SEQ_STOPPED: begin
        if ((pendFf & maskFf) != 16'h0000 && clockResumed) nxt_seq = SEQ_IDLE; // [R13]
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seqFf <= SEQ_IDLE;
    end else begin
      seqFf <= nxt_seq;
    end
  end

  // stop bit reads 1 after the first write and while stopped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stopBitFf <= 1'b0;
    end else begin
      stopBitFf <= (nxt_seq == SEQ_ONE) || (nxt_seq == SEQ_STOPPED); // [R23]
    end
  end

  // exit flag: set wins over software clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stopExitFf <= 1'b0;
    end else if (seqFf == SEQ_STOPPED && nxt_seq == SEQ_IDLE) begin
      stopExitFf <= 1'b1; // [R12]
    end else if (regWr && regAddr == OFS_STOP_EXIT && regWdata[0]) begin
      stopExitFf <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lineIrq     <= 1'b0;
      stopReq     <= 1'b0;
      standbyWake <= 1'b0;
    end else begin
      lineIrq     <= genEnFf && ((pendFf & maskFf) != 16'h0000); // [R02] [R07] [R25]
      stopReq     <= (nxt_seq == SEQ_STOPPED);
      standbyWake <= wakeSyncBFf; // [R21]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      unique case (regAddr)
        OFS_SWIRQ_LOW:  regRdata <= {24'h000000, swFf[7:0]};
        OFS_SWIRQ_HIGH: regRdata <= {24'h000000, swFf[15:8]};
        OFS_LINE_CTRL:  regRdata <= {29'h0, stopBitFf, genEnFf, wakeModeFf}; // [R19]
        OFS_MASK_LOW:   regRdata <= {24'h000000, maskFf[7:0]};
        OFS_MASK_HIGH:  regRdata <= {24'h000000, maskFf[15:8]};
        OFS_EDGE_LOW:   regRdata <= {24'h000000, edgeFf[7:0]};
        OFS_EDGE_HIGH:  regRdata <= {24'h000000, edgeFf[15:8]};
        OFS_PEND_LOW:   regRdata <= {24'h000000, pendFf[7:0]};
        OFS_PEND_HIGH:  regRdata <= {24'h000000, pendFf[15:8]};
        OFS_STOP_EXIT:  regRdata <= {31'h0, stopExitFf};
        default:        regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  a_irq_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !genEnFf |=> !lineIrq) else $error("irq while global enable off"); // [R07]
  a_irq_source: assert property (@(posedge clk) disable iff (sys_rst)
    ((pendFf & maskFf) == 16'h0000) |=> !lineIrq) else $error("irq with nothing pending"); // [R25]
  a_edge_pend: assert property (@(posedge clk) disable iff (sys_rst)
    (edgeHit[3] && maskFf[3]) |=> pendFf[3]) else $error("edge did not set pending"); // [R26]
  a_mask_block: assert property (@(posedge clk) disable iff (sys_rst)
    (!maskFf[4] && !swFf[4] && !pendFf[4] && pendClr[4] == 1'b0) |=> !pendFf[4])
    else $error("masked line set pending"); // [R04]
  a_stop_mode: assert property (@(posedge clk) disable iff (sys_rst)
    (seqFf != SEQ_STOPPED && !wakeModeFf) |=> seqFf != SEQ_STOPPED)
    else $error("stop entered outside wake mode"); // [R22]
  a_stop_nomask: assert property (@(posedge clk) disable iff (sys_rst)
    (seqFf != SEQ_STOPPED && maskFf == 16'h0000) |=> seqFf != SEQ_STOPPED)
    else $error("stop entered with all lines masked"); // [R16]
  sequence s_first_one;
    wrCtrl && ctrlStop && seqFf == SEQ_IDLE;
  endsequence
  a_first_write: assert property (@(posedge clk) disable iff (sys_rst)
    s_first_one |=> stopBitFf) else $error("stop bit not set"); // [R23]
  a_ack_abort: assert property (@(posedge clk) disable iff (sys_rst)
    (irqAck && (seqFf == SEQ_ONE || seqFf == SEQ_ZERO)) |=> seqFf == SEQ_IDLE)
    else $error("ack did not abort sequence"); // [R10]
  a_zero_twice: assert property (@(posedge clk) disable iff (sys_rst)
    (seqFf == SEQ_ZERO && wrCtrl && !ctrlStop) |=> seqFf == SEQ_IDLE)
    else $error("double zero kept tracker"); // [R09]
  a_exit_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (seqFf == SEQ_STOPPED && nxt_seq == SEQ_IDLE) |=> ##1 stopExitFf && !stopBitFf)
    else $error("exit status wrong after wake"); // [R12]

  // control and configuration writes
  a_ctrl_wake: assert property (
    wrCtrl |=> wakeModeFf == $past(regWdata[CTRL_WAKE_BIT]))
    else $error("wake mode not stored"); // [R06]

  a_ctrl_gen: assert property (
    wrCtrl |=> genEnFf == $past(regWdata[CTRL_GEN_BIT]))
    else $error("global enable not stored"); // [R24]

  a_mask_write: assert property (
    (regWr && regAddr == OFS_MASK_LOW) |=> maskFf[7:0] == $past(regWdata[7:0]))
    else $error("mask low not stored"); // [R04]

  a_mask_high: assert property (
    (regWr && regAddr == OFS_MASK_HIGH) |=> maskFf[15:8] == $past(regWdata[7:0]))
    else $error("mask high not stored"); // [R04]

  a_edge_write: assert property (
    (regWr && regAddr == OFS_EDGE_LOW) |=> edgeFf[7:0] == $past(regWdata[7:0]))
    else $error("edge low not stored"); // [R05]

  a_edge_high: assert property (
    (regWr && regAddr == OFS_EDGE_HIGH) |=> edgeFf[15:8] == $past(regWdata[7:0]))
    else $error("edge high not stored"); // [R05]

  // pending bits
  a_pend_edges: assert property (
    (pendSet == 16'h0000) |=> (pendFf & ~$past(pendFf)) == 16'h0000)
    else $error("pending set without event"); // [R14]

  a_pend_clear: assert property (
    (pendClr[5] && !pendSet[5]) |=> !pendFf[5])
    else $error("pending low not cleared"); // [R14]

  a_pend_hclr: assert property (
    (pendClr[12] && !pendSet[12]) |=> !pendFf[12])
    else $error("pending high not cleared"); // [R14]

  a_fall_pend: assert property (
    (!edgeFf[6] && !syncBFf[6] && lineDlyFf[6] && maskFf[6]) |=> pendFf[6])
    else $error("falling edge missed"); // [R05]

  a_sw_event: assert property (
    (swFf[0] && maskFf[0]) |=> pendFf[0])
    else $error("software event lost"); // [R20]

  a_line0_nohw: assert property (
    !syncAFf[LINE_SW])
    else $error("line 0 has a hardware source"); // [R03]

  a_usb_route: assert property (
    syncAFf[LINE_USB] == $past(usbSuspendExit))
    else $error("usb event not on line 1"); // [R03]

  // interrupt request and standby wake
  a_irq_raise: assert property (
    (genEnFf && (pendFf & maskFf) != 16'h0000) |=> lineIrq)
    else $error("request missing"); // [R25]

  a_standby_pin: assert property (
    standbyWake == $past(wakeSyncBFf))
    else $error("standby wake not from pin"); // [R21]

  // stop tracker steps
  sequence s_one_zero;
    seqFf == SEQ_ONE && wrCtrl && !ctrlStop && !irqAck && pendSet == 16'h0000;
  endsequence

  sequence s_third_one;
    seqFf == SEQ_ZERO && wrCtrl && ctrlStop && stopOk && !irqAck;
  endsequence

  a_seq_second: assert property (
    s_one_zero |=> seqFf == SEQ_ZERO)
    else $error("zero write not taken"); // [R08]

  a_seq_third: assert property (
    s_third_one |=> seqFf == SEQ_STOPPED && stopReq)
    else $error("good sequence not stopped"); // [R08]

  a_idle_hold: assert property (
    (seqFf == SEQ_IDLE && !(wrCtrl && ctrlStop)) |=> seqFf == SEQ_IDLE)
    else $error("tracker left idle"); // [R09]

  a_event_abort: assert property (
    (pendSet != 16'h0000 && (seqFf == SEQ_ONE || seqFf == SEQ_ZERO)) |=> seqFf == SEQ_IDLE)
    else $error("event did not abort"); // [R11]

  a_stop_pend: assert property (
    (seqFf == SEQ_ZERO && wrCtrl && (pendFf & maskFf) != 16'h0000) |=> seqFf != SEQ_STOPPED)
    else $error("stop with pending line"); // [R15]

  a_stop_bit: assert property (
    stopBitFf == (seqFf == SEQ_ONE || seqFf == SEQ_STOPPED))
    else $error("stop bit out of step"); // [R23]

  a_stop_out: assert property (
    stopReq == (seqFf == SEQ_STOPPED))
    else $error("stop request out of step"); // [R13]

  // stop exit
  a_wake_exit: assert property (
    (seqFf == SEQ_STOPPED && (pendFf & maskFf) != 16'h0000 && clockResumed) |=> !stopReq)
    else $error("wake did not end stop"); // [R13]

  a_stop_hold: assert property (
    (seqFf == SEQ_STOPPED && (pendFf & maskFf) == 16'h0000) |=> seqFf == SEQ_STOPPED)
    else $error("stop left with no event"); // [R13]

  a_exit_sticky: assert property (
    (stopExitFf && !(regWr && regAddr == OFS_STOP_EXIT)) |=> stopExitFf)
    else $error("exit flag lost"); // [R12]

  a_exit_clear: assert property (
    (regWr && regAddr == OFS_STOP_EXIT && regWdata[0] && seqFf != SEQ_STOPPED) |=> !stopExitFf)
    else $error("exit flag not cleared"); // [R12]

  a_no_exit: assert property (
    (!stopExitFf && seqFf != SEQ_STOPPED) |=> !stopExitFf)
    else $error("exit flag without stop"); // [R10] [R11]

  // register reads
  a_rd_idle: assert property (
    !regRd |=> regRdata == 32'h0000_0000)
    else $error("read data outside read"); // [R19]

  a_rd_ctrl: assert property (
    (regRd && regAddr == OFS_LINE_CTRL) |=>
      regRdata == {29'h0, $past(stopBitFf), $past(genEnFf), $past(wakeModeFf)})
    else $error("control read wrong"); // [R19]

  a_rd_exit: assert property (
    (regRd && regAddr == OFS_STOP_EXIT) |=> regRdata == {31'h0, $past(stopExitFf)})
    else $error("exit flag read wrong"); // [R12]
endmodule : ewiu_external_wake_interrupt_unit

/* verif/ewiu_partner_model.sv */
/*
  partner model: interrupt controller acknowledge and clock power unit restart.
  assumes it shares the unit's clock and synchronous reset.
*/
module ewiu_partner_model #(
  parameter int RESTART = 8
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic stopReq,
  input  wire logic ackReq,
  output logic      irqAck,
  output logic      clockResumed
);
  timeunit 1ns;
  timeprecision 1ns;
  int restartCnt;
  // oscillator restart delay counted only while the unit is stopped
  always_ff @(posedge clk) begin
    if (sys_rst || !stopReq) restartCnt <= 0;
    else if (restartCnt < RESTART) restartCnt <= restartCnt + 1;
  end
  assign clockResumed = stopReq && (restartCnt == RESTART);
  // no acknowledge unless asked: channel masked for resume-only wake
  always_ff @(posedge clk) irqAck <= !sys_rst && ackReq;
endmodule : ewiu_partner_model

/* verif/testbench.sv */
/*
  self-checking bench for the external wake interrupt unit.
  assumes the partner model answers acknowledges and clock restart.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ewiu_pkg::*;
  typedef struct packed {logic [3:0] pin; logic rise; logic msk; logic gen; logic irq;} ewiu_row_t;
  logic                 clk = 1'h0;
  logic                 sys_rst = 1'h1;
  logic                 regWr = 1'h0;
  logic                 regRd = 1'h0;
  logic                 usbSuspendExit = 1'h0;
  logic                 rtcAlarm = 1'h0;
  logic                 ackReq = 1'h0;
  logic [7:0]           regAddr = 8'h00;
  logic [31:0]          regWdata = 32'h0;
  logic [31:0]          regRdata;
  logic [PIN_LINES-1:0] pinLines = '0;
  logic                 irqAck, clockResumed, lineIrq, stopReq, standbyWake;
  int                   failures = 0;
  int                   checks = 0;
  ewiu_row_t rows [5] = '{'{4'h0, 1'h1, 1'h1, 1'h1, 1'h1}, '{4'h3, 1'h0, 1'h1, 1'h1, 1'h0},
    '{4'hC, 1'h1, 1'h1, 1'h1, 1'h1}, '{4'hC, 1'h1, 1'h0, 1'h1, 1'h0},
    '{4'h5, 1'h1, 1'h1, 1'h0, 1'h0}};
  always #50 clk = ~clk;
  ewiu_external_wake_interrupt_unit uut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .pinLines(pinLines), .usbSuspendExit(usbSuspendExit), .rtcAlarm(rtcAlarm),
    .irqAck(irqAck), .clockResumed(clockResumed), .lineIrq(lineIrq), .stopReq(stopReq),
    .standbyWake(standbyWake));
  ewiu_partner_model pm (.clk(clk), .sys_rst(sys_rst), .stopReq(stopReq), .ackReq(ackReq),
    .irqAck(irqAck), .clockResumed(clockResumed));
  task automatic conclude();
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= {24'h0, d};
    @(posedge clk);
    regWr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'h0;
    #1 chk(what, {24'h0, exp}, regRdata);
  endtask : rd
  task automatic clrPend();
    wr(OFS_PEND_LOW, 8'hFF);
    wr(OFS_PEND_HIGH, 8'hFF);
  endtask : clrPend
  // sequence 1,0,1 with a read between when stop is expected; refused attempts reset the tracker after
  task automatic tryStop(input logic [7:0] c, input logic ack, input logic ev, input logic exp);
    wr(OFS_LINE_CTRL, c | 8'h04);
    if (exp) rd(OFS_LINE_CTRL, c | 8'h04, "stop bit after first write");
    if (ack) ackReq <= 1'h1;
    if (ev) pinLines[0] <= 1'h1;
    repeat (6) @(posedge clk);
    ackReq <= 1'h0;
    wr(OFS_LINE_CTRL, c);
    wr(OFS_LINE_CTRL, c | 8'h04);
    repeat (4) @(posedge clk);
    #1 chk("stopReq", {31'h0, exp}, {31'h0, stopReq});
    if (!exp) begin
      rd(OFS_STOP_EXIT, 8'h00, "exit flag after refusal");
      pinLines[0] <= 1'h0;
      clrPend();
      wr(OFS_LINE_CTRL, c);
      wr(OFS_LINE_CTRL, c);
    end
  endtask : tryStop
  initial begin : main
    ewiu_row_t r;
    int ln;
    logic [15:0] e;
    logic [15:0] m;
    logic [7:0] pr;
    int n;
    repeat (20) @(posedge clk);
    sys_rst <= 1'h0;
    rd(OFS_LINE_CTRL, 8'h00, "ctrl after reset");
    chk("stopReq after reset", 32'h0, {31'h0, stopReq});
    wr(8'h80, 8'hFF);
    rd(8'h80, 8'h00, "unmapped read");
    foreach (rows[i]) begin
      r = rows[i];
      ln = r.pin + 2;
      m = 16'(r.msk) << ln;
      e = 16'(r.rise) << ln;
      pr = (ln < 8) ? OFS_PEND_LOW : OFS_PEND_HIGH;
      wr(OFS_MASK_LOW, m[7:0]);
      wr(OFS_MASK_HIGH, m[15:8]);
      wr(OFS_EDGE_LOW, e[7:0]);
      wr(OFS_EDGE_HIGH, e[15:8]);
      wr(OFS_LINE_CTRL, {6'h0, r.gen, 1'h0});
      pinLines[r.pin] <= 1'h1;
      repeat (6) @(posedge clk);
      #1 chk("lineIrq", {31'h0, r.irq}, {31'h0, lineIrq});
      if (r.msk) rd(pr, (ln < 8) ? e[7:0] : e[15:8], "pending");
      clrPend();
      rd(pr, 8'h00, "pending cleared while held");
      pinLines[r.pin] <= 1'h0;
      repeat (6) @(posedge clk);
      clrPend();
    end
    wr(OFS_MASK_LOW, 8'h03);
    wr(OFS_MASK_HIGH, 8'h80);
    wr(OFS_EDGE_LOW, 8'h02);
    wr(OFS_EDGE_HIGH, 8'h80);
    wr(OFS_SWIRQ_LOW, 8'h01);
    usbSuspendExit <= 1'h1;
    rtcAlarm <= 1'h1;
    pinLines[13] <= 1'h1;
    repeat (6) @(posedge clk);
    #1 chk("standbyWake", 32'h1, {31'h0, standbyWake});
    rd(OFS_PEND_LOW, 8'h03, "sw and usb pending");
    rd(OFS_PEND_HIGH, 8'h80, "alarm pending");
    wr(OFS_SWIRQ_LOW, 8'h00);
    usbSuspendExit <= 1'h0;
    rtcAlarm <= 1'h0;
    pinLines[13] <= 1'h0;
    clrPend();
    wr(OFS_MASK_LOW, 8'h05);
    wr(OFS_MASK_HIGH, 8'h00);
    wr(OFS_EDGE_LOW, 8'h05);
    wr(OFS_EDGE_HIGH, 8'h00);
    tryStop(8'h02, 1'h0, 1'h0, 1'h0);
    tryStop(8'h03, 1'h1, 1'h0, 1'h0);
    tryStop(8'h03, 1'h0, 1'h1, 1'h0);
    pinLines[0] <= 1'h1;
    repeat (6) @(posedge clk);
    tryStop(8'h03, 1'h0, 1'h0, 1'h0);
    wr(OFS_MASK_LOW, 8'h00);
    tryStop(8'h03, 1'h0, 1'h0, 1'h0);
    wr(OFS_MASK_LOW, 8'h05);
    wr(OFS_LINE_CTRL, 8'h07);
    wr(OFS_LINE_CTRL, 8'h03);
    wr(OFS_LINE_CTRL, 8'h03);
    wr(OFS_LINE_CTRL, 8'h07);
    repeat (4) @(posedge clk);
    #1 chk("stopReq after double zero", 32'h0, {31'h0, stopReq});
    wr(OFS_LINE_CTRL, 8'h03);
    wr(OFS_LINE_CTRL, 8'h03);
    tryStop(8'h03, 1'h0, 1'h0, 1'h1);
    rd(OFS_LINE_CTRL, 8'h07, "ctrl while stopped");
    pinLines[0] <= 1'h1;
    n = 0;
    while (stopReq !== 1'h0) begin
      if (n == 200) begin
        failures++;
        conclude();
      end
      n++;
      @(posedge clk);
    end
    rd(OFS_LINE_CTRL, 8'h03, "ctrl after wake");
    rd(OFS_STOP_EXIT, 8'h01, "exit flag after wake");
    wr(OFS_STOP_EXIT, 8'h01);
    rd(OFS_STOP_EXIT, 8'h00, "exit flag cleared");
    conclude();
  end : main
endmodule : testbench
